// File: rtl/lpc_ctrl.sv
// Low power mode controller with AHB-Lite register slave.
// Assumes one clock, a core that signals return from interrupt, and
// peripherals that raise wake events synchronous to clk.
// How it works
// R1 - Software request enters each low-power mode
// R2 - Interrupt wakes cpu_off/standby, return re-enters mode
// R3 - Rtc_only and shutdown cut core supply
// R4 - Main clock and cpu run only active
// R5 - Sub clock, lock loop, oscillators off standby+
// R6 - Ref osc and aux clock off from off_mode
// R7 - Low clocks allowed except off and shutdown
// R8 - Off_mode keeps low clocks on peripheral request
// R9 - System clock limit 16 MHz, 40 kHz, zero
// R10 - Wake instant, 10 us, or 350 us
// R11 - Wake sources qualified by mode
// R12 - Program memory and RAM power by mode
// R13 - Backup registers kept except in shutdown
// R14 - Timers and watchdog off from off_mode
// R15 - Serial and CRC off from standby
// R16 - ADC off from off_mode
// R17 - RTC off in off and shutdown
// R18 - Pins hold state from standby down
// R19 - Brownout always, supervisor, regulator by mode
// R20 - Deep wake restarts core from power-up
`timescale 1ns/1ps
`include "lpc_defs.svh"

module lpc_ctrl
  import lpc_pkg::*;
#(
  parameter int unsigned WAKE_DP_CYC = `LPC_CYC_DP
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Core
  input  wire logic        isr_done,
  output logic             cpu_run,
  output logic             cpu_wake,
  output logic             core_restart,
  // Wake events and low clock request
  input  wire logic        wake_pin,
  input  wire logic        wake_rtc,
  input  wire logic        wake_periph,
  input  wire logic        lf_req,
  // Clock gates
  output logic             mclk_en,
  output logic             sub_main_clock_en,
  output logic             frequency_lock_loop_en,
  output logic             digital_osc_en,
  output logic             modulation_clock_en,
  output logic             ref_rc_osc_en,
  output logic             aclk_en,
  output logic             xtal_en,
  output logic             vlo_en,
  output logic [1:0]       sysclk_lim,
  // Power
  output logic             core_supply,
  output logic             fram_pwr,
  output logic             ram_pwr,
  output logic             bkp_pwr,
  output logic             supply_supervisor_en,
  output logic             bor_en,
  output logic [1:0]       reg_state,
  // Peripheral enables and pins
  output logic [3:0]       timer_en,
  output logic             watchdog_timer_en,
  output logic [2:0]       ser_en,
  output logic             crc_en,
  output logic             adc_en,
  output logic             rtc_en,
  output logic             gpio_act,
  output logic             gpio_hold
);

  logic [9:0]  clk_opt_q;
  logic [10:0] per_opt_q;
  logic [2:0]  wake_en_q;
  logic        rst_flag_q;
  logic [31:0] bkp_q [`LPC_BKP_WORDS];
  lpc_mode_e   mode_q;
  lpc_st_e     st_q;
  logic        ret_q;
  logic [16:0] cnt_q;
  logic [16:0] wk_len_q;
  logic        wr_q;
  logic [7:0]  wa_q;
  logic [31:0] rd_d;
  logic        wake_ok;

  // Address phase decode
  wire acc  = hsel & htrans[1] & hready;
  wire hit  = haddr[31:8] == 24'h000000;
  wire deep = (mode_q == M_RTC_ONLY) || (mode_q == M_SHUTDOWN);
  wire sleeping = st_q != S_RUN;
  wire lpc_mode_e req_m = lpc_mode_e'(hwdata[2:0]);
  wire mode_wr = wr_q && (wa_q == `LPC_OFS_MODE) && (hwdata[2:0] < 3'h6);
  wire wake_done = (st_q == S_SLEEP && wake_ok && mode_q == M_CPU_OFF)
                || (st_q == S_WAKE && cnt_q == 17'h00000);
  wire lpc_mode_e em = sleeping ? mode_q : M_ACTIVE;
  wire bkp_wr = wr_q && wa_q[7:5] == `LPC_OFS_BKP;

  // Bus answer is zero wait, always OKAY
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write address capture for the data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= acc & hwrite & hit;
      wa_q <= haddr[7:0];
    end
  end

  // Read mux, unmapped reads give zero
  always_comb begin
    rd_d = 32'h00000000;
    if (hit) begin
      case (haddr[7:0])
        `LPC_OFS_MODE: rd_d = {29'h0, mode_q};
        `LPC_OFS_CLK:  rd_d = {22'h0, clk_opt_q};
        `LPC_OFS_PER:  rd_d = {21'h0, per_opt_q};
        `LPC_OFS_WAKE: rd_d = {29'h0, wake_en_q};
        `LPC_OFS_STAT: rd_d = {23'h0, rst_flag_q, 2'h0, st_q,
                               ret_q, mode_q};
        default: begin
          if (haddr[7:5] == `LPC_OFS_BKP)
            rd_d = bkp_q[haddr[4:2]];
        end
      endcase
    end
  end

  // Read data stands through the data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (acc & ~hwrite)
      hrdata <= rd_d;
  end

  // Option and wake enable registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_opt_q <= `LPC_CLK_RST;
      per_opt_q <= `LPC_PER_RST;
      wake_en_q <= `LPC_WAKE_RST;
    end else if (wr_q) begin
      if (wa_q == `LPC_OFS_CLK)
        clk_opt_q <= hwdata[9:0];
      if (wa_q == `LPC_OFS_PER)
        per_opt_q <= hwdata[10:0];
      if (wa_q == `LPC_OFS_WAKE)
        wake_en_q <= hwdata[2:0];
    end
  end

  // Backup words, wiped while sitting in shutdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `LPC_BKP_WORDS; i++)
        bkp_q[i] <= 32'h00000000;
    end else if (st_q == S_SLEEP && mode_q == M_SHUTDOWN) begin
      for (int i = 0; i < `LPC_BKP_WORDS; i++)
        bkp_q[i] <= 32'h00000000; // R13
    end else if (bkp_wr) begin
      bkp_q[wa_q[4:2]] <= hwdata;
    end
  end

  // Restart flag, write one clears, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rst_flag_q <= 1'b0;
    else if (wake_done && deep)
      rst_flag_q <= 1'b1;
    else if (wr_q && wa_q == `LPC_OFS_STAT && hwdata[`LPC_ST_RST])
      rst_flag_q <= 1'b0;
  end

  // Wake source qualification per mode
  always_comb begin
    case (mode_q)
      M_CPU_OFF, M_STANDBY:
        wake_ok = |(wake_en_q & {wake_periph, wake_rtc, wake_pin}); // R11
      M_OFF, M_SHUTDOWN:
        wake_ok = wake_en_q[`LPC_WK_PIN] & wake_pin; // R11
      M_RTC_ONLY:
        wake_ok = (wake_en_q[`LPC_WK_PIN] & wake_pin)
                | (wake_en_q[`LPC_WK_RTC] & wake_rtc); // R11
      default:
        wake_ok = 1'b0;
    endcase
  end

  // Mode sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= S_RUN;
      mode_q <= M_ACTIVE;
      ret_q  <= 1'b0;
      cnt_q  <= 17'h00000;
    end else begin
      case (st_q)
        S_RUN: begin
          if (mode_wr) begin
            if (ret_q) begin
              if (req_m == M_ACTIVE) begin
                ret_q  <= 1'b0;
                mode_q <= M_ACTIVE;
              end else begin
                mode_q <= req_m;
              end
            end else if (req_m != M_ACTIVE) begin
              mode_q <= req_m; // R1
              st_q   <= S_SLEEP;
            end
          end else if (ret_q && isr_done) begin
            st_q <= S_SLEEP; // R2
          end
        end
        S_SLEEP: begin
          if (wake_ok) begin
            if (mode_q == M_CPU_OFF) begin
              st_q  <= S_RUN; // R10
              ret_q <= 1'b1; // R2
            end else begin
              st_q  <= S_WAKE;
              cnt_q <= deep ? 17'(WAKE_DP_CYC - 1)
                            : 17'(`LPC_CYC_STB - 1); // R10
            end
          end
        end
        S_WAKE: begin
          if (cnt_q == 17'h00000) begin
            st_q <= S_RUN;
            if (mode_q == M_STANDBY) begin
              ret_q <= 1'b1; // R2
            end else begin
              ret_q  <= 1'b0; // R20
              mode_q <= M_ACTIVE;
            end
          end else begin
            cnt_q <= cnt_q - 17'h00001;
          end
        end
        default: st_q <= S_RUN;
      endcase
    end
  end

  // Core wake and restart pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_wake     <= 1'b0;
      core_restart <= 1'b0;
    end else begin
      cpu_wake     <= wake_done & ~deep;
      core_restart <= wake_done & deep; // R20
    end
  end

  // Clock gates follow the effective mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mclk_en    <= 1'b0;
      cpu_run    <= 1'b0;
      sub_main_clock_en      <= 1'b0;
      frequency_lock_loop_en <= 1'b0;
      digital_osc_en         <= 1'b0;
      modulation_clock_en    <= 1'b0;
      ref_rc_osc_en          <= 1'b0;
      aclk_en    <= 1'b0;
      xtal_en    <= 1'b0;
      vlo_en     <= 1'b0;
      sysclk_lim <= `LPC_SYS_NONE;
    end else begin
      mclk_en   <= em == M_ACTIVE; // R4
      cpu_run   <= em == M_ACTIVE; // R4
      sub_main_clock_en      <= em <= M_CPU_OFF &&
                                clk_opt_q[`LPC_CK_SUB]; // R5
      frequency_lock_loop_en <= em <= M_CPU_OFF &&
                                clk_opt_q[`LPC_CK_LOCK]; // R5
      digital_osc_en         <= em <= M_CPU_OFF &&
                                clk_opt_q[`LPC_CK_OSC]; // R5
      modulation_clock_en    <= em <= M_CPU_OFF &&
                                clk_opt_q[`LPC_CK_MOD]; // R5
      ref_rc_osc_en          <= em <= M_STANDBY &&
                                clk_opt_q[`LPC_CK_REF]; // R6
      aclk_en   <= em <= M_STANDBY && clk_opt_q[`LPC_CK_AUX]; // R6
      xtal_en   <= clk_opt_q[`LPC_CK_XTL] &&
                   (em == M_OFF ? lf_req : em != M_SHUTDOWN); // R7 R8
      vlo_en    <= clk_opt_q[`LPC_CK_VLO] &&
                   (em == M_OFF ? lf_req : em != M_SHUTDOWN); // R7 R8
      if (em <= M_CPU_OFF)
        sysclk_lim <= `LPC_SYS_16M; // R9
      else if (em == M_STANDBY || em == M_RTC_ONLY)
        sysclk_lim <= `LPC_SYS_40K; // R9
      else
        sysclk_lim <= `LPC_SYS_NONE; // R9
    end
  end

  // Power domains, regulator and supervisors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_supply <= 1'b0;
      fram_pwr    <= 1'b0;
      ram_pwr     <= 1'b0;
      bkp_pwr     <= 1'b0;
      supply_supervisor_en <= 1'b0;
      bor_en      <= 1'b0;
      reg_state   <= `LPC_REG_DOWN;
    end else begin
      core_supply <= em <= M_OFF; // R3
      fram_pwr    <= em <= M_CPU_OFF; // R12
      ram_pwr     <= em <= M_OFF; // R12
      bkp_pwr     <= em != M_SHUTDOWN; // R13
      supply_supervisor_en <= em <= M_CPU_OFF ||
                              clk_opt_q[`LPC_CK_SUPV]; // R19
      bor_en      <= 1'b1; // R19
      if (em <= M_CPU_OFF)
        reg_state <= `LPC_REG_FULL; // R19
      else if (em == M_SHUTDOWN)
        reg_state <= `LPC_REG_DOWN; // R19
      else
        reg_state <= `LPC_REG_PART; // R19
    end
  end

  // Peripheral enables and pin control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_en  <= 4'h0;
      watchdog_timer_en <= 1'b0;
      ser_en    <= 3'h0;
      crc_en    <= 1'b0;
      adc_en    <= 1'b0;
      rtc_en    <= 1'b0;
      gpio_act  <= 1'b0;
      gpio_hold <= 1'b0;
    end else begin
      timer_en  <= {4{em <= M_STANDBY}} &
                   per_opt_q[`LPC_PE_TMR +: 4]; // R14
      watchdog_timer_en <= em <= M_STANDBY &&
                           per_opt_q[`LPC_PE_WDOG]; // R14
      ser_en    <= {3{em <= M_CPU_OFF}} &
                   per_opt_q[`LPC_PE_SER +: 3]; // R15
      crc_en    <= em <= M_CPU_OFF && per_opt_q[`LPC_PE_CRC]; // R15
      adc_en    <= em <= M_STANDBY && per_opt_q[`LPC_PE_ADC]; // R16
      rtc_en    <= (em <= M_STANDBY || em == M_RTC_ONLY) &&
                   per_opt_q[`LPC_PE_RTC]; // R17
      gpio_act  <= em == M_ACTIVE ||
                   (em == M_CPU_OFF && clk_opt_q[`LPC_CK_GPIO]); // R18
      gpio_hold <= em >= M_STANDBY; // R18
    end
  end

  // Cycles spent in the wake delay, for checking only
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      wk_len_q <= 17'h00000;
    else if (st_q == S_WAKE)
      wk_len_q <= wk_len_q + 17'h00001;
    else
      wk_len_q <= 17'h00000;
  end

  a_sleep_cpu_off: assert property (@(posedge clk) disable iff (rst) // R4
    st_q == S_SLEEP |=> !cpu_run && !mclk_en)
    else $error("cpu clock running while asleep");

  a_sub_clk_off: assert property (@(posedge clk) disable iff (rst) // R5
    sleeping && mode_q >= M_STANDBY |=> !sub_main_clock_en &&
    !digital_osc_en && !frequency_lock_loop_en && !modulation_clock_en)
    else $error("fast clocks on in standby or deeper");

  a_lf_clk_off: assert property (@(posedge clk) disable iff (rst) // R7
    sleeping && mode_q == M_SHUTDOWN |=> !xtal_en && !vlo_en &&
    !ref_rc_osc_en)
    else $error("low clocks on in shutdown");

  a_off_lf_req: assert property (@(posedge clk) disable iff (rst) // R8
    sleeping && mode_q == M_OFF && lf_req && clk_opt_q[`LPC_CK_XTL]
    |=> xtal_en)
    else $error("crystal dropped despite request in off mode");

  a_core_supply: assert property (@(posedge clk) disable iff (rst) // R3
    !$past(rst) |-> (!core_supply == ($past(sleeping) && $past(deep))))
    else $error("core supply does not match mode");

  a_stb_wake_len: assert property (@(posedge clk) disable iff (rst) // R10
    st_q == S_WAKE && cnt_q == 17'h00000 && mode_q == M_STANDBY
    |-> wk_len_q == 17'(`LPC_CYC_STB - 1))
    else $error("standby wake length wrong");

  a_dp_wake_len: assert property (@(posedge clk) disable iff (rst) // R10
    st_q == S_WAKE && cnt_q == 17'h00000 && deep
    |-> wk_len_q == 17'(WAKE_DP_CYC - 1))
    else $error("deep wake length wrong");

  a_off_no_rtc: assert property (@(posedge clk) disable iff (rst) // R11
    st_q == S_SLEEP && mode_q == M_OFF && !wake_pin |=> st_q == S_SLEEP)
    else $error("off mode woke without pin event");

  a_isr_return: assert property (@(posedge clk) disable iff (rst) // R2
    st_q == S_RUN && ret_q && isr_done && !mode_wr
    |=> st_q == S_SLEEP ##1 !cpu_run)
    else $error("no return to low power after interrupt");

  a_deep_restart: assert property (@(posedge clk) disable iff (rst) // R20
    wake_done && deep |=> core_restart && !cpu_wake && mode_q == M_ACTIVE)
    else $error("deep wake did not restart core");

  a_bkp_kept: assert property (@(posedge clk) disable iff (rst) // R13
    !$past(rst) |->
      (!bkp_pwr == ($past(sleeping) && $past(mode_q) == M_SHUTDOWN)))
    else $error("backup power does not match mode");

  a_bor_on: assert property (@(posedge clk) disable iff (rst) // R19
    !$past(rst) |-> bor_en)
    else $error("brownout detection off");

  a_pins_held: assert property (@(posedge clk) disable iff (rst) // R18
    sleeping && mode_q >= M_STANDBY |=> gpio_hold && !gpio_act)
    else $error("pins not held in standby or deeper");

endmodule // lpc_ctrl

// File: include/lpc_defs.svh
// Offsets, field positions, reset values and timing counts of the
// low power mode controller. Included by its bare name.
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

// Register byte offsets
`define LPC_OFS_MODE 8'h00
`define LPC_OFS_CLK  8'h04
`define LPC_OFS_PER  8'h08
`define LPC_OFS_WAKE 8'h0C
`define LPC_OFS_STAT 8'h10
`define LPC_OFS_BKP  3'h2
`define LPC_BKP_BYTES 32
`define LPC_BKP_WORDS (`LPC_BKP_BYTES / 4)

// Clock option fields
`define LPC_CK_SUB  0
`define LPC_CK_LOCK 1
`define LPC_CK_OSC  2
`define LPC_CK_MOD  3
`define LPC_CK_REF  4
`define LPC_CK_AUX  5
`define LPC_CK_XTL  6
`define LPC_CK_VLO  7
`define LPC_CK_SUPV 8
`define LPC_CK_GPIO 9

// Peripheral option fields
`define LPC_PE_TMR  0
`define LPC_PE_WDOG 4
`define LPC_PE_SER  5
`define LPC_PE_CRC  8
`define LPC_PE_ADC  9
`define LPC_PE_RTC  10

// Wake enable fields and status fields
`define LPC_WK_PIN  0
`define LPC_WK_RTC  1
`define LPC_WK_PER  2
`define LPC_ST_RST  8

// Reset values
`define LPC_CLK_RST  10'h000
`define LPC_PER_RST  11'h000
`define LPC_WAKE_RST 3'h7

// Regulator and system clock limit codes
`define LPC_REG_FULL 2'h0
`define LPC_REG_PART 2'h1
`define LPC_REG_DOWN 2'h2
`define LPC_SYS_NONE 2'h0
`define LPC_SYS_40K  2'h1
`define LPC_SYS_16M  2'h2

// Timing
`define LPC_CLK_MHZ       200
`define LPC_T_WAKE_STB_US 10
`define LPC_T_WAKE_DP_US  350
`define LPC_CYC_STB (`LPC_T_WAKE_STB_US * `LPC_CLK_MHZ)
`define LPC_CYC_DP  (`LPC_T_WAKE_DP_US * `LPC_CLK_MHZ)

`endif

// File: include/lpc_pkg.sv
// Types of the low power mode controller.
// Mode order runs from shallowest to deepest.
package lpc_pkg;

  typedef enum logic [2:0] {
    M_ACTIVE, M_CPU_OFF, M_STANDBY, M_OFF, M_RTC_ONLY, M_SHUTDOWN
  } lpc_mode_e;

  typedef enum logic [1:0] {S_RUN, S_SLEEP, S_WAKE} lpc_st_e;

endpackage

// File: sim/lpc_core_model.sv
// Core model: returns from the wake interrupt a set time after resume.
// Assumes cpu_wake is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps

module lpc_core_model #(
  parameter int ISR_LEN = 40
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Core handshake
  input  wire logic cpu_wake,
  input  wire logic isr_en,
  output logic      isr_done
);
  int cnt_q;

  // Count the handler length, pulse done once at its end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q    <= 0;
      isr_done <= 1'b0;
    end else begin
      isr_done <= (cnt_q == 1);
      if (cpu_wake && isr_en) begin
        cnt_q <= ISR_LEN;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule // lpc_core_model

// File: sim/tb_top.sv
// Bench: bus tasks, walk through every mode, wake timing and sources.
// Assumes a zero wait state slave and a shortened deep wake count.
`timescale 1ns/1ps
`include "lpc_defs.svh"

module tb_top;
  import lpc_pkg::*;
  localparam int DP = 20;
  localparam logic [31:0] MODE = 32'(`LPC_OFS_MODE);
  localparam logic [31:0] STAT = 32'(`LPC_OFS_STAT);
  localparam logic [31:0] BK0  = 32'h0000_0040;
  localparam logic [31:0] BK7  = 32'h0000_005C;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, lf_req = 0;
  logic        isr_en = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, wk = 0;
  logic        hreadyout, hresp, isr_done, cpu_run, cpu_wake, core_restart;
  logic        mclk_en, sub_main_clock_en, frequency_lock_loop_en;
  logic        digital_osc_en, modulation_clock_en, ref_rc_osc_en;
  logic        aclk_en, xtal_en, vlo_en, core_supply, fram_pwr, ram_pwr;
  logic        bkp_pwr, supply_supervisor_en, bor_en, crc_en, adc_en, rtc_en;
  logic        watchdog_timer_en, gpio_act, gpio_hold;
  logic [1:0]  sysclk_lim, reg_state;
  logic [3:0]  timer_en;
  logic [2:0]  ser_en;
  logic [31:0] hrdata;
  int          err_total = 0, cmp_count = 0, n_wake = 0, n_rst = 0;
  wire  [32:0] obs = {cpu_run, mclk_en, sub_main_clock_en,
    frequency_lock_loop_en, digital_osc_en, modulation_clock_en,
    ref_rc_osc_en, aclk_en, xtal_en, vlo_en, core_supply, fram_pwr,
    ram_pwr, bkp_pwr, supply_supervisor_en, bor_en, timer_en,
    watchdog_timer_en, ser_en, crc_en,
    adc_en, rtc_en, gpio_act, gpio_hold, sysclk_lim, reg_state};

  // Clock and design under test
  always #2.5 clk = ~clk;
  lpc_ctrl #(.WAKE_DP_CYC(DP)) DUT (.clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .isr_done, .cpu_run, .cpu_wake, .core_restart,
    .wake_pin(wk[0]), .wake_rtc(wk[1]), .wake_periph(wk[2]), .lf_req,
    .mclk_en, .sub_main_clock_en, .frequency_lock_loop_en, .digital_osc_en,
    .modulation_clock_en, .ref_rc_osc_en, .aclk_en,
    .xtal_en, .vlo_en, .sysclk_lim, .core_supply, .fram_pwr, .ram_pwr,
    .bkp_pwr, .supply_supervisor_en, .bor_en, .reg_state, .timer_en,
    .watchdog_timer_en, .ser_en,
    .crc_en, .adc_en, .rtc_en, .gpio_act, .gpio_hold);
  lpc_core_model #(.ISR_LEN(40)) u_core (.clk, .rst, .cpu_wake, .isr_en,
    .isr_done);

  // Count resume and restart pulses
  always @(posedge clk) begin
    if (cpu_wake === 1'b1) n_wake++;
    if (core_restart === 1'b1) n_rst++;
  end

  // Outputs expected per mode with every option enabled
  function automatic logic [32:0] exp_out(int m);
    logic a, l, s, k;
    a = (m == 0);
    l = (m <= 1);
    s = (m <= 2);
    k = s || (m == 4);
    return {a, a, {4{l}}, s, s, k, k, m <= 3, l, m <= 3, m <= 4, 2'h3,
      {5{s}}, {4{l}}, s, k, l, m >= 2,
      l ? 2'h2 : (m == 2 || m == 4) ? 2'h1 : 2'h0,
      l ? 2'h0 : (m == 5) ? 2'h2 : 2'h1};
  endfunction

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One single AHB-Lite transfer, address phase then data phase
  task automatic bus(logic w, logic [31:0] a, d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(string nm, logic [31:0] a, ex);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, ex);
  endtask

  // One-cycle wake event on source s
  task automatic pulse(int s);
    @(posedge clk);
    wk[s] <= 1'b1;
    @(posedge clk);
    wk[s] <= 1'b0;
    #1;
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (cpu_run !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #300000;
    err_total++;
    stop_test();
  end

  // Main sequence
  initial begin
    int n, t, src, nw, nr;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk("run after reset", {cpu_run, mclk_en, bor_en}, 3'h7);
    rd("clk opt", 32'(`LPC_OFS_CLK), 32'h0);
    rd("per opt", 32'(`LPC_OFS_PER), 32'h0);
    rd("wake en", 32'(`LPC_OFS_WAKE), 32'h7);
    rd("unmapped", 32'h0000_0100, 32'h0);
    chk("hresp", hresp, 1'b0);
    wr(32'(`LPC_OFS_CLK), 32'h3FF);
    wr(32'(`LPC_OFS_PER), 32'h7FF);
    wr(BK0, 32'hA5A5_0001);
    wr(BK7, 32'h5A5A_0008);
    wr(MODE, 32'h6);
    rd("bad mode", MODE, 32'h0);
    cyc(2);
    chk("active out", obs, exp_out(0));
    for (int m = 1; m <= 5; m++) begin
      isr_en <= (m <= 2);
      wr(MODE, m);
      cyc(2);
      chk("sleep out", obs, exp_out(m));
      if (m == 3) begin
        @(posedge clk);
        lf_req <= 1'b1;
        cyc(3);
        chk("lf clocks", {xtal_en, vlo_en}, 2'h3);
        @(posedge clk);
        lf_req <= 1'b0;
        cyc(3);
      end
      // Sources that must not wake this mode
      for (int s = 1; s <= 2; s++) begin
        if (!(m <= 2 || (m == 4 && s == 1))) begin
          pulse(s);
          cyc(3);
          rd("ignored", STAT, 32'h10 | m);
        end
      end
      // A disabled source must not wake even the shallowest mode
      if (m == 1) begin
        wr(32'(`LPC_OFS_WAKE), 32'h3);
        pulse(2);
        cyc(3);
        rd("masked", STAT, 32'h11);
        wr(32'(`LPC_OFS_WAKE), 32'h7);
      end
      src = (m == 1) ? 2 : (m == 2 || m == 4) ? 1 : 0;
      t = (m == 1) ? 0 : (m <= 3) ? 2000 : DP;
      nw = n_wake;
      nr = n_rst;
      pulse(src);
      wait_run(n);
      chk("wake time", n >= t && n <= t + 5, 1'b1);
      cyc(2);
      chk("pulses", {n_wake - nw, n_rst - nr},
          m >= 4 ? 64'h1 : 64'h1 << 32);
      chk("awake out", obs, exp_out(0));
      if (m <= 2) begin
        cyc(45);
        chk("reenter", obs, exp_out(m));
        pulse(src);
        wait_run(n);
        wr(MODE, 32'h0);
        cyc(50);
        chk("cancel", obs, exp_out(0));
      end
      if (m >= 4) begin
        rd("restart", STAT, 32'h100);
        wr(STAT, 32'h100);
        rd("restart clr", STAT, 32'h0);
        rd("bkp 0", BK0, m == 4 ? 32'hA5A5_0001 : 32'h0);
        rd("bkp 7", BK7, m == 4 ? 32'h5A5A_0008 : 32'h0);
      end
    end
    stop_test();
  end
endmodule // tb_top
